// ===== hdl/sleep_wake_pkg.sv
package sleep_wake_pkg;

    // ------------------------------------------------------------
    // modes and states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {MODE_PINS, MODE_UART, MODE_SPI} transport_e;
    typedef enum logic [1:0] {ST_OFF, ST_AWAKE, ST_SLEEP, ST_EVENT} pwr_state_e;

    localparam int CNT_W = 16;
    typedef logic [CNT_W-1:0] count_t;

    // ------------------------------------------------------------
    // configuration written by the host over the cfg strobe
    // ------------------------------------------------------------
    typedef struct packed {
        logic sleepEn;
        logic wakePolHigh;
        logic hostWakePolHigh;
        transport_e mode;
        logic spiSleepEn;
        count_t spiIdleTime;
        count_t wakeTime;
        logic scanEn;
        count_t scanInterval;
    } cfg_s;

    localparam cfg_s CFG_RESET = '{
        sleepEn: 1'h0,
        wakePolHigh: 1'h0,
        hostWakePolHigh: 1'h0,
        mode: MODE_PINS,
        spiSleepEn: 1'h0,
        spiIdleTime: 16'h0040,
        wakeTime: 16'h0000,
        scanEn: 1'h0,
        scanInterval: 16'h0800
    };

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLOCK_MHZ = 200;
    localparam int WAKE_SETTLE_NS = 100;
    localparam int WAKE_SETTLE_CYC = (WAKE_SETTLE_NS * CLOCK_MHZ + 999) / 1000;
    localparam logic [7:0] SETTLE_DONE = 8'(WAKE_SETTLE_CYC);

    // level of a wake line from its logical meaning, or back; symmetric
    function automatic logic polMap(input logic value, input logic polHigh);
        return polHigh ? value : ~value;
    endfunction

endpackage

// ===== hdl/sleep_wake_if.sv
`timescale 1ns/1ps

interface sleep_wake_if;
    import sleep_wake_pkg::*;

    // host to device
    logic deviceWakeReq;
    logic uartCtsN;
    logic hostChipSelectN;
    logic regEn;
    logic cfgWrite;
    cfg_s cfgData;
    // device to host
    logic hostWake;
    logic uartRtsN;
    logic spiInt;
    logic clkReq;

    modport dev (
        input deviceWakeReq, uartCtsN, hostChipSelectN, regEn, cfgWrite, cfgData,
        output hostWake, uartRtsN, spiInt, clkReq
    );

    modport host (
        output deviceWakeReq, uartCtsN, hostChipSelectN, regEn, cfgWrite, cfgData,
        input hostWake, uartRtsN, spiInt, clkReq
    );

endinterface

// ===== hdl/sleep_wake_handshake_ctrl.sv
`timescale 1ns/1ps

// Function
// - sleep powers down and gates nonessential logic
// - sleep timed by oscillator, wakes timer/host
// - scan or sniff event wakes, then resleeps
// - periodic event timer clocked by oscillator
// - host may wake sleeping device anytime
// - host wake keeps device awake between events
// - dropping wake request means sleep request
// - device wake input forces awake state in pins mode
// - wake polarity selectable, active low default
// - host wake output with selectable polarity
// - uart cts wakes device, rts wakes host
// - spi idle chip select times into sleep
// - host programs spi idle sleep and time
// - chip select assertion wakes spi device
// - spi interrupt wakes host for pending data
// - clock request asserted while reference needed
// - regulator enable high powers, low disables
// - separate tx, rx, pll, pa power downs
// - regulator enable restart is full power-on
// - low power link modes run from oscillator
module sleep_wake_handshake_ctrl
    import sleep_wake_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // link to the host
    sleep_wake_if.dev link,
    // baseband side
    input wire logic lowPowerOsc,
    input wire logic dataPending,
    input wire logic eventDone,
    input wire logic txActive,
    input wire logic rxActive,
    input wire logic rxReady,
    // power and status
    output logic regOn,
    output logic sleeping,
    output logic scanEvent,
    output logic pdTx,
    output logic pdRx,
    output logic pdPll,
    output logic pdPa
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        pwr_state_e state;
        cfg_s cfg;
        logic [1:0] wakeSync;
        logic [1:0] csSync;
        logic [1:0] ctsSync;
        logic [2:0] lpoSync;
        count_t sleepCnt;
        count_t scanCnt;
        count_t idleCnt;
        logic regOn;
        logic sleeping;
        logic scanEvent;
        logic hostWake;
        logic rtsN;
        logic spiInt;
        logic clkReq;
        logic pdTx;
        logic pdRx;
        logic pdPll;
        logic pdPa;
    } dev_s;

    localparam dev_s DEV_RESET = '{
        state: ST_OFF,
        cfg: CFG_RESET,
        wakeSync: 2'h3,
        csSync: 2'h3,
        ctsSync: 2'h3,
        hostWake: 1'h1,
        rtsN: 1'h1,
        pdTx: 1'h1,
        pdRx: 1'h1,
        pdPll: 1'h1,
        pdPa: 1'h1,
        default: '0
    };

    dev_s st_reg;
    dev_s st_next;
    logic lpoTick;
    logic wakeReq;
    logic sleepOk;
    logic active;
    logic hostWakeOn;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.scanEvent = 1'h0;
        // first stages feed only the second stages
        st_next.wakeSync = {st_reg.wakeSync[0], link.deviceWakeReq};
        st_next.csSync = {st_reg.csSync[0], link.hostChipSelectN};
        st_next.ctsSync = {st_reg.ctsSync[0], link.uartCtsN};
        st_next.lpoSync = {st_reg.lpoSync[1:0], lowPowerOsc};
        lpoTick = st_reg.lpoSync[1] & ~st_reg.lpoSync[2];

        case (st_reg.cfg.mode)
            MODE_UART: wakeReq = ~st_reg.ctsSync[1];
            MODE_SPI: wakeReq = ~st_reg.csSync[1];
            default: wakeReq = polMap(st_reg.wakeSync[1], st_reg.cfg.wakePolHigh);
        endcase

        if (link.cfgWrite) begin
            st_next.cfg = link.cfgData;
        end

        // event timer runs on oscillator ticks in every powered state
        if (!st_reg.cfg.scanEn) begin
            st_next.scanCnt = '0;
        end else if (lpoTick) begin
            if (st_reg.scanCnt >= st_reg.cfg.scanInterval) begin
                st_next.scanCnt = '0;
                st_next.scanEvent = 1'h1;
            end else begin
                st_next.scanCnt = st_reg.scanCnt + 16'h0001;
            end
        end

        // idle chip select counted in core clocks while awake
        if (st_reg.cfg.mode == MODE_SPI && st_reg.csSync[1] && st_reg.state == ST_AWAKE) begin
            if (st_reg.idleCnt != '1) begin
                st_next.idleCnt = st_reg.idleCnt + 16'h0001;
            end
        end else begin
            st_next.idleCnt = '0;
        end

        if (st_reg.cfg.mode == MODE_SPI) begin
            sleepOk = st_reg.cfg.spiSleepEn && !dataPending
                && st_reg.idleCnt >= st_reg.cfg.spiIdleTime;
        end else begin
            sleepOk = st_reg.cfg.sleepEn && !wakeReq && !dataPending;
        end

        case (st_reg.state)
            ST_OFF: begin
                st_next.state = ST_AWAKE;
            end
            ST_AWAKE: begin
                // events while awake are serviced in place, no sleep between them
                if (sleepOk) begin
                    st_next.state = ST_SLEEP;
                    st_next.sleepCnt = '0;
                end
            end
            ST_SLEEP: begin
                if (wakeReq || dataPending) begin
                    st_next.state = ST_AWAKE;
                end else if (st_next.scanEvent) begin
                    st_next.state = ST_EVENT;
                end else if (lpoTick) begin
                    if (st_reg.cfg.wakeTime != '0 && st_reg.sleepCnt >= st_reg.cfg.wakeTime - 16'h0001) begin
                        st_next.state = ST_AWAKE;
                    end else begin
                        st_next.sleepCnt = st_reg.sleepCnt + 16'h0001;
                    end
                end
            end
            ST_EVENT: begin
                if (eventDone) begin
                    st_next.state = wakeReq ? ST_AWAKE : ST_SLEEP;
                    st_next.sleepCnt = '0;
                end
            end
            default: begin
                st_next.state = ST_OFF;
            end
        endcase

        // ------------------------------------------------------------
        // outputs from the next state
        // ------------------------------------------------------------
        active = st_next.state == ST_AWAKE || st_next.state == ST_EVENT;
        st_next.sleeping = st_next.state == ST_SLEEP;
        st_next.clkReq = active;
        st_next.pdTx = !(active && txActive);
        st_next.pdRx = !(active && rxActive);
        st_next.pdPll = !(active && (txActive || rxActive));
        st_next.pdPa = !(active && txActive);

        hostWakeOn = dataPending && st_reg.cfg.mode != MODE_SPI;
        st_next.hostWake = polMap(hostWakeOn, st_reg.cfg.hostWakePolHigh);
        // rts doubles as host wake on top of receive flow control
        st_next.rtsN = (st_reg.cfg.mode == MODE_UART) ? ~(hostWakeOn || (active && rxReady)) : 1'h1;
        // chip select left high means the host may be asleep
        st_next.spiInt = st_reg.cfg.mode == MODE_SPI && dataPending && st_reg.csSync[1];
        st_next.regOn = link.regEn;

        // regulator off loses everything, including configuration
        if (!link.regEn) begin
            st_next = DEV_RESET;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= DEV_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // ports
    // ------------------------------------------------------------
    assign link.hostWake = st_reg.hostWake;
    assign link.uartRtsN = st_reg.rtsN;
    assign link.spiInt = st_reg.spiInt;
    assign link.clkReq = st_reg.clkReq;
    assign regOn = st_reg.regOn;
    assign sleeping = st_reg.sleeping;
    assign scanEvent = st_reg.scanEvent;
    assign pdTx = st_reg.pdTx;
    assign pdRx = st_reg.pdRx;
    assign pdPll = st_reg.pdPll;
    assign pdPa = st_reg.pdPa;

endmodule // sleep_wake_handshake_ctrl

// ===== hdl/sleep_wake_host.sv
`timescale 1ns/1ps

module sleep_wake_host
    import sleep_wake_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // link to the device
    sleep_wake_if.host link,
    // host software side
    input wire logic powerOn,
    input wire logic wantAwake,
    input wire logic cfgLoad,
    input wire cfg_s cfgIn,
    output logic deviceReady,
    output logic attention
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        cfg_s cfg;
        logic cfgWrite;
        logic [7:0] settle;
        logic wakeLevel;
        logic ctsN;
        logic csN;
        logic regEn;
        logic ready;
        logic attention;
    } host_s;

    localparam host_s HOST_RESET = '{
        cfg: CFG_RESET,
        wakeLevel: 1'h1,
        ctsN: 1'h1,
        csN: 1'h1,
        default: '0
    };

    host_s st_reg;
    host_s st_next;
    logic wake;

    always_comb begin
        st_next = st_reg;
        st_next.cfgWrite = cfgLoad && powerOn;
        if (cfgLoad && powerOn) begin
            st_next.cfg = cfgIn;
        end
        st_next.regEn = powerOn;
        wake = wantAwake && powerOn;

        // only the line of the chosen transport carries the request
        st_next.wakeLevel = polMap(wake && st_reg.cfg.mode == MODE_PINS, st_reg.cfg.wakePolHigh);
        st_next.ctsN = ~(wake && st_reg.cfg.mode == MODE_UART);
        st_next.csN = ~(wake && st_reg.cfg.mode == MODE_SPI);

        // ready held low until the request has stood long enough; the line itself is driven at once
        if (!wake) begin
            st_next.settle = '0;
        end else if (st_reg.settle != SETTLE_DONE) begin
            st_next.settle = st_reg.settle + 8'h01;
        end
        st_next.ready = wake && st_next.settle == SETTLE_DONE;

        case (st_reg.cfg.mode)
            MODE_UART: st_next.attention = ~link.uartRtsN;
            MODE_SPI: st_next.attention = link.spiInt;
            default: st_next.attention = polMap(link.hostWake, st_reg.cfg.hostWakePolHigh);
        endcase

        if (!powerOn) begin
            st_next = HOST_RESET;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= HOST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // ports
    // ------------------------------------------------------------
    assign link.deviceWakeReq = st_reg.wakeLevel;
    assign link.uartCtsN = st_reg.ctsN;
    assign link.hostChipSelectN = st_reg.csN;
    assign link.regEn = st_reg.regEn;
    assign link.cfgWrite = st_reg.cfgWrite;
    assign link.cfgData = st_reg.cfg;
    assign deviceReady = st_reg.ready;
    assign attention = st_reg.attention;

endmodule // sleep_wake_host

// ===== dv/sleep_wake_asserts.sv
`timescale 1ns/1ps

module sleep_wake_asserts
    import sleep_wake_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // host to device
    input wire logic deviceWakeReq,
    input wire logic uartCtsN,
    input wire logic hostChipSelectN,
    input wire logic regEn,
    input wire logic cfgWrite,
    input wire cfg_s cfgData,
    // device to host
    input wire logic hostWake,
    input wire logic uartRtsN,
    input wire logic spiInt,
    input wire logic clkReq
);
    logic wakeIn;

    // wake meaning of the line that the selected transport uses
    always_comb begin
        case (cfgData.mode)
            MODE_UART: wakeIn = !uartCtsN;
            MODE_SPI: wakeIn = !hostChipSelectN;
            default: wakeIn = cfgData.wakePolHigh ? deviceWakeReq : !deviceWakeReq;
        endcase
    end

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_offNow;
        !regEn;
    endsequence
    // allows for the two sync flops and the state register
    sequence s_wakeHeld;
        (regEn && wakeIn) [*5];
    endsequence

    a_off_clkreq: assert property (s_offNow |=> !clkReq) else $error("clkReq high after regulator off");
    a_off_outputs: assert property (s_offNow |=> hostWake && uartRtsN && !spiInt) else $error("outputs kept");
    a_wake_clkreq: assert property (s_wakeHeld |-> clkReq) else $error("held wake did not wake");
    a_sleep_release: assert property ($fell(clkReq) |-> !$past(regEn) ||
        !($past(wakeIn, 2) && $past(wakeIn, 3) && $past(wakeIn, 4))) else $error("slept under wake");
    a_rise_regen: assert property ($rose(clkReq) |-> $past(regEn)) else $error("clkReq rose unpowered");
    a_rts_idle: assert property ((regEn && cfgData.mode != MODE_UART) [*3] |-> uartRtsN)
        else $error("rts low outside uart mode");
    a_spiint_cs: assert property ((!hostChipSelectN) [*4] |-> !spiInt) else $error("spiInt with cs low");
    a_spiint_mode: assert property ((cfgData.mode != MODE_SPI) [*3] |-> !spiInt)
        else $error("spiInt outside spi mode");
endmodule // sleep_wake_asserts

// ===== dv/sleep_wake_handshake_ctrl_tb_top.sv
`timescale 1ns/1ps

module sleep_wake_handshake_ctrl_tb_top
    import sleep_wake_pkg::*;
;
    logic clock, rst_n, dataPending, eventDone, txActive, rxActive, rxReady;
    logic powerOn, wantAwake, cfgLoad, regOn, sleeping, scanEvent, pdTx, pdRx, pdPll, pdPa;
    logic deviceReady, attention;
    logic [3:0] oscDiv;
    cfg_s cfgIn, cfg;
    int err_total, checked, n;

    sleep_wake_if link();
    sleep_wake_handshake_ctrl u_sleep_wake_handshake_ctrl (.clock(clock), .rst_n(rst_n), .link(link),
        .lowPowerOsc(oscDiv[3]), .dataPending(dataPending), .eventDone(eventDone), .txActive(txActive),
        .rxActive(rxActive), .rxReady(rxReady), .regOn(regOn), .sleeping(sleeping), .scanEvent(scanEvent),
        .pdTx(pdTx), .pdRx(pdRx), .pdPll(pdPll), .pdPa(pdPa));
    sleep_wake_host u_sleep_wake_host (.clock(clock), .rst_n(rst_n), .link(link), .powerOn(powerOn),
        .wantAwake(wantAwake), .cfgLoad(cfgLoad), .cfgIn(cfgIn), .deviceReady(deviceReady),
        .attention(attention));
    sleep_wake_asserts u_sleep_wake_asserts (.clock(clock), .rst_n(rst_n),
        .deviceWakeReq(link.deviceWakeReq), .uartCtsN(link.uartCtsN), .hostChipSelectN(link.hostChipSelectN),
        .regEn(link.regEn), .cfgWrite(link.cfgWrite), .cfgData(link.cfgData), .hostWake(link.hostWake),
        .uartRtsN(link.uartRtsN), .spiInt(link.spiInt), .clkReq(link.clkReq));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    // slow oscillator: one rising edge every 16 core cycles
    always @(posedge clock) oscDiv <= oscDiv + 4'h1;

    task step(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask
    task check1(input string what, input logic exp, input logic got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask
    task load(input cfg_s c);
        @(posedge clock) cfgIn <= c;
        cfgLoad <= 1'b1;
        @(posedge clock) cfgLoad <= 1'b0;
        step(4);
    endtask
    // returns after the update, so callers read the new request level
    task setWake(input logic v);
        @(posedge clock) wantAwake <= v;
        #1;
    endtask
    task waitSleep(input logic v, input int lim);
        n = 0;
        while (sleeping !== v && n < lim) begin
            step(1);
            n++;
        end
        check1("sleeping", v, sleeping);
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_power;
        check1("clkReq off", 1'b0, link.clkReq);
        check1("pdRx off", 1'b1, pdRx);
        @(posedge clock) powerOn <= 1'b1;
        txActive <= 1'b1;
        step(5);
        check1("regOn", 1'b1, regOn);
        check1("clkReq on", 1'b1, link.clkReq);
        check1("wake low", 1'b0, link.deviceWakeReq);
        check1("pdTx", 1'b0, pdTx);
        check1("pdRx", 1'b1, pdRx);
        check1("pdPll", 1'b0, pdPll);
        check1("pdPa", 1'b0, pdPa);
        @(posedge clock) txActive <= 1'b0;
        rxActive <= 1'b1;
        step(3);
        check1("pdTx rx", 1'b1, pdTx);
        check1("pdRx rx", 1'b0, pdRx);
        check1("pdPll rx", 1'b0, pdPll);
        check1("pdPa rx", 1'b1, pdPa);
        @(posedge clock) rxActive <= 1'b0;
    endtask
    task t_pins;
        cfg = CFG_RESET;
        cfg.sleepEn = 1'b1;
        load(cfg);
        setWake(1'b0);
        waitSleep(1'b1, 50);
        check1("clkReq asleep", 1'b0, link.clkReq);
        check1("pdPll asleep", 1'b1, pdPll);
        setWake(1'b1);
        waitSleep(1'b0, 20);
        check1("wake latency", 1'b1, n >= 4 && n <= 6);
        check1("ready early", 1'b0, deviceReady);
        step(WAKE_SETTLE_CYC - 5);
        check1("ready late", 1'b0, deviceReady);
        step(1);
        check1("ready", 1'b1, deviceReady);
    endtask
    task t_polarity;
        cfg = CFG_RESET;
        cfg.wakePolHigh = 1'b1;
        cfg.hostWakePolHigh = 1'b1;
        load(cfg);
        check1("wake high", 1'b1, link.deviceWakeReq);
        @(posedge clock) dataPending <= 1'b1;
        step(3);
        check1("hostWake high", 1'b1, link.hostWake);
        check1("attention high", 1'b1, attention);
        load(CFG_RESET);
        check1("hostWake low", 1'b0, link.hostWake);
        check1("attention low", 1'b1, attention);
        @(posedge clock) dataPending <= 1'b0;
        step(3);
        check1("hostWake idle", 1'b1, link.hostWake);
        check1("attention idle", 1'b0, attention);
    endtask
    task t_uart;
        cfg = CFG_RESET;
        cfg.mode = MODE_UART;
        cfg.sleepEn = 1'b1;
        load(cfg);
        check1("cts wake", 1'b0, link.uartCtsN);
        @(posedge clock) rxReady <= 1'b1;
        step(3);
        check1("rts ready", 1'b0, link.uartRtsN);
        check1("attention rts", 1'b1, attention);
        @(posedge clock) rxReady <= 1'b0;
        setWake(1'b0);
        waitSleep(1'b1, 50);
        check1("cts idle", 1'b1, link.uartCtsN);
        setWake(1'b1);
        waitSleep(1'b0, 20);
    endtask
    task t_spi;
        cfg = CFG_RESET;
        cfg.mode = MODE_SPI;
        cfg.spiSleepEn = 1'b1;
        cfg.spiIdleTime = 16'h0010;
        load(cfg);
        setWake(1'b0);
        waitSleep(1'b1, 100);
        check1("idle time", 1'b1, n >= 16);
        setWake(1'b1);
        waitSleep(1'b0, 20);
        check1("cs low", 1'b0, link.hostChipSelectN);
        setWake(1'b0);
        @(posedge clock) dataPending <= 1'b1;
        step(6);
        check1("spiInt", 1'b1, link.spiInt);
        check1("attention spi", 1'b1, attention);
        @(posedge clock) dataPending <= 1'b0;
        setWake(1'b1);
        step(6);
    endtask
    task t_scan;
        cfg = CFG_RESET;
        cfg.sleepEn = 1'b1;
        cfg.scanEn = 1'b1;
        cfg.scanInterval = 16'h0003;
        load(cfg);
        repeat (2) begin
            if (wantAwake === 1'b0) waitSleep(1'b1, 50);
            n = 0;
            while (scanEvent !== 1'b1 && n < 200) begin
                step(1);
                n++;
            end
            check1("scanEvent", 1'b1, scanEvent);
            step(2);
            check1("event awake", 1'b0, sleeping);
            @(posedge clock) eventDone <= 1'b1;
            step(4);
            check1("after event", !wantAwake, sleeping);
            @(posedge clock) eventDone <= 1'b0;
            setWake(!wantAwake);
        end
        step(6);
    endtask
    task t_timer;
        cfg = CFG_RESET;
        cfg.sleepEn = 1'b1;
        cfg.wakeTime = 16'h0004;
        load(cfg);
        setWake(1'b0);
        waitSleep(1'b1, 50);
        waitSleep(1'b0, 200);
        check1("timer span", 1'b1, n >= 48);
        setWake(1'b1);
        step(6);
    endtask
    task t_regoff;
        @(posedge clock) powerOn <= 1'b0;
        step(3);
        check1("regOn off", 1'b0, regOn);
        check1("clkReq down", 1'b0, link.clkReq);
        check1("pdTx down", 1'b1, pdTx);
        @(posedge clock) powerOn <= 1'b1;
        wantAwake <= 1'b0;
        step(30);
        check1("cfg forgotten", 1'b0, sleeping);
        check1("wake idle", 1'b1, link.deviceWakeReq);
    endtask

    initial begin
        rst_n = 1'b0;
        oscDiv = 4'h0;
        {dataPending, eventDone, txActive, rxActive, rxReady, powerOn, cfgLoad} = 7'h00;
        wantAwake = 1'b1;
        cfgIn = CFG_RESET;
        err_total = 0;
        checked = 0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        step(1);
        t_power;
        t_pins;
        t_polarity;
        t_uart;
        t_spi;
        t_scan;
        t_timer;
        t_regoff;
        test_done;
    end

    initial begin
        #60us;
        err_total++;
        $display("watchdog expired");
        test_done;
    end
endmodule // sleep_wake_handshake_ctrl_tb_top
